// ---- logic/uic_channel.sv ----
`timescale 1ns/1ns
// Functional notes
// - Four interrupt enables, reset off, top zero.
// - Receive interrupt on data or trigger level.
// - FIFO receive interrupt clears below trigger.
// - Data ready set on push, clears empty.
// - Enabling transmit-empty while empty raises it.
// - Overrun immediate; errors at head only.
// - Status bit 0 low while pending.
// - Priority source codes on status bits 3..0.
// - Status shows only highest pending source.
// - Status bits 7:6 mirror FIFO enable.
// - Timeout after four chars plus 12 bits.
// - Transmit-empty raised empty, cleared read/write.
// - Line status read clears line interrupt.
// - Modem changes raise; status read clears.
// - FIFO enable bit gates other control bits.
// - FIFO reset bits clear pointers, self-clear.
// - DMA bit switches ready pin signalling.
// - Trigger select: 1, 4, 8, 14.
// - Line bit 7: any errored FIFO char.
// - Line bit 6: FIFO and shifter empty.
// - Divisor bank switch at offsets 0, 1.
module uic_channel #(
   parameter int DEPTH = uic_pkg::FIFO_DEPTH_DEF
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char_data,
   input wire logic rx_parity_err,
   input wire logic rx_frame_err,
   input wire logic rx_break,
   input wire logic bit_tick,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_take,
   input wire logic tx_shift_empty,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic cd_n,
   output logic irq,
   output logic irq_oe,
   output logic rx_ready_pin_n,
   output logic tx_ready_pin_n,
   output logic [15:0] divisor,
   output logic [7:0] line_ctrl,
   output logic dtr_n,
   output logic rts_n,
   output logic aux_out1_n,
   output logic aux_out2_n,
   output logic loopback
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] CAP_FULL = CW'(DEPTH);
   localparam logic [CW-1:0] CAP_ONE = CW'(1);

   // The trigger level of 14 needs at least 16 entries and pointers wrap by power of two.
   initial begin
      if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("uic_channel: DEPTH must be a power of two, at least 16.");
      end
   end

   // Register bank and control state.
   logic [7:0] line_ctrl_reg, next_line_ctrl_reg;
   logic [4:0] modem_ctrl_reg, next_modem_ctrl_reg;
   logic [7:0] scratch_reg, next_scratch_reg;
   logic [7:0] divisor_low_reg, next_divisor_low_reg;
   logic [7:0] divisor_high_reg, next_divisor_high_reg;
   logic [3:0] int_enable_reg, next_int_enable_reg;
   logic fifo_en, next_fifo_en;
   logic dma_mode, next_dma_mode;
   logic [1:0] trig_sel, next_trig_sel;
   // Strobe edge detection and read data.
   logic rd_q, wr_q;
   logic [7:0] next_data_out;
   // FIFO storage and pointers.
   logic [10:0] rx_mem [DEPTH];
   logic [7:0] tx_mem [DEPTH];
   logic [PW-1:0] rx_rp, rx_wp, tx_rp, tx_wp;
   logic [PW-1:0] next_rx_rp, next_rx_wp, next_tx_rp, next_tx_wp;
   logic [CW-1:0] rx_cnt, tx_cnt, next_rx_cnt, next_tx_cnt;
   // Interrupt state.
   logic overrun, next_overrun;
   logic ls_seen, next_ls_seen;
   logic [6:0] tmo_cnt, next_tmo_cnt;
   logic thre_int, next_thre_int;
   logic tx_empty_q;
   logic [3:0] mdm_q;
   logic [3:0] mdm_delta, next_mdm_delta;
   logic rx_dma_act, next_rx_dma_act;

   // Decode of the bus strobes; each access acts once, on the cycle its strobe goes low.
   logic rd_act, wr_act, rd_go, wr_go, dlab;
   logic rhr_rd, thr_wr, ier_wr, fcr_wr, isr_rd, lsr_rd, msr_rd;
   assign rd_act = ~cs_n & ~rd_n;
   assign wr_act = ~cs_n & ~wr_n;
   assign rd_go = rd_act & ~rd_q;
   assign wr_go = wr_act & ~wr_q;
   assign dlab = line_ctrl_reg[uic_pkg::LCR_DLAB];
   assign rhr_rd = rd_go && addr == uic_pkg::OFS_DATA && !dlab;
   assign thr_wr = wr_go && addr == uic_pkg::OFS_DATA && !dlab;
   assign ier_wr = wr_go && addr == uic_pkg::OFS_IER && !dlab;
   assign fcr_wr = wr_go && addr == uic_pkg::OFS_ISR_FCR;
   assign isr_rd = rd_go && addr == uic_pkg::OFS_ISR_FCR;
   assign lsr_rd = rd_go && addr == uic_pkg::OFS_LSR;
   assign msr_rd = rd_go && addr == uic_pkg::OFS_MSR;

   // FIFO control decode: a write with the enable bit low only turns the FIFOs off and empties them.
   logic fcr_prog, fifo_toggle, rx_clr, tx_clr;
   assign fcr_prog = fcr_wr && data_in[uic_pkg::FCR_EN];
   assign fifo_toggle = fcr_wr && (data_in[uic_pkg::FCR_EN] != fifo_en);
   assign rx_clr = (fcr_prog && data_in[uic_pkg::FCR_RXRST]) || fifo_toggle;
   assign tx_clr = (fcr_prog && data_in[uic_pkg::FCR_TXRST]) || fifo_toggle;

   // Without FIFOs each path holds one character, so one set of pointers serves both modes.
   logic [CW-1:0] cap;
   logic rx_push, rx_pop, tx_push, tx_pop, rx_any, tx_empty;
   assign cap = fifo_en ? CAP_FULL : CAP_ONE;
   assign rx_any = rx_cnt != '0;
   assign tx_empty = tx_cnt == '0;
   assign rx_push = rx_char_valid && rx_cnt < cap;
   assign rx_pop = rhr_rd && rx_any;
   assign tx_push = thr_wr && tx_cnt < cap;
   assign tx_pop = tx_take && !tx_empty;

   // Head character and its error tags.
   logic [10:0] rx_head;
   logic head_err;
   assign rx_head = rx_mem[rx_rp];
   assign head_err = rx_any && (|rx_head[10:8]);

   // Global error flag over every held character.
   logic fifo_err;
   always_comb begin
      logic [PW-1:0] idx;
      idx = '0;
      fifo_err = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
         idx = rx_rp + PW'(i);
         if (CW'(i) < rx_cnt && |rx_mem[idx][10:8]) begin
            fifo_err = 1'b1;
         end
      end
   end

   // Trigger level selection.
   logic [4:0] trig_lvl;
   always_comb begin
      case (trig_sel)
         2'h0: trig_lvl = uic_pkg::TRIG_1;
         2'h1: trig_lvl = uic_pkg::TRIG_4;
         2'h2: trig_lvl = uic_pkg::TRIG_8;
         2'h3: trig_lvl = uic_pkg::TRIG_14;
         default: trig_lvl = uic_pkg::TRIG_1;
      endcase
   end

   // Timeout limit follows the programmed frame length, counted in bit times.
   logic [6:0] frame_bits, tmo_limit;
   logic tmo_hit, rxd_lvl;
   assign frame_bits = uic_pkg::FRAME_BASE_BITS + 7'(line_ctrl_reg[1:0])
                       + 7'(line_ctrl_reg[uic_pkg::LCR_PEN]) + 7'(line_ctrl_reg[uic_pkg::LCR_STB]);
   assign tmo_limit = 7'(uic_pkg::TMO_CHARS * frame_bits) + uic_pkg::TMO_EXTRA_BITS;
   assign tmo_hit = fifo_en && rx_any && tmo_cnt == tmo_limit;
   // The level compare drops as soon as reads take the count below the trigger.
   assign rxd_lvl = fifo_en ? (rx_cnt >= CW'(trig_lvl)) : rx_any;

   // Modem inputs, replaced by the control bits in loopback.
   logic [3:0] mdm;
   assign mdm = modem_ctrl_reg[uic_pkg::MCR_LOOP]
                ? {modem_ctrl_reg[uic_pkg::MCR_OUT2], modem_ctrl_reg[uic_pkg::MCR_OUT1],
                   modem_ctrl_reg[uic_pkg::MCR_DTR], modem_ctrl_reg[uic_pkg::MCR_RTS]}
                : {~cd_n, ~ri_n, ~dsr_n, ~cts_n};

   // Source qualification and priority encoding; only the top source is shown.
   logic ls_src, tmo_src, rxd_src, thre_src, mdm_src;
   logic [3:0] src_code;
   assign ls_src = int_enable_reg[uic_pkg::IER_LS] && (overrun || (head_err && !ls_seen));
   assign tmo_src = int_enable_reg[uic_pkg::IER_RXD] && tmo_hit;
   assign rxd_src = int_enable_reg[uic_pkg::IER_RXD] && rxd_lvl;
   assign thre_src = int_enable_reg[uic_pkg::IER_THRE] && thre_int;
   assign mdm_src = int_enable_reg[uic_pkg::IER_MDM] && (|mdm_delta);
   always_comb begin
      if (ls_src) begin
         src_code = uic_pkg::SRC_LS;
      end else if (tmo_src) begin
         src_code = uic_pkg::SRC_TMO;
      end else if (rxd_src) begin
         src_code = uic_pkg::SRC_RXD;
      end else if (thre_src) begin
         src_code = uic_pkg::SRC_THRE;
      end else if (mdm_src) begin
         src_code = uic_pkg::SRC_MDM;
      end else begin
         src_code = uic_pkg::SRC_NONE;
      end
   end

   // Register writes and the FIFO control fields.
   always_comb begin
      next_line_ctrl_reg = line_ctrl_reg;
      next_modem_ctrl_reg = modem_ctrl_reg;
      next_scratch_reg = scratch_reg;
      next_divisor_low_reg = divisor_low_reg;
      next_divisor_high_reg = divisor_high_reg;
      next_int_enable_reg = int_enable_reg;
      next_fifo_en = fifo_en;
      next_dma_mode = dma_mode;
      next_trig_sel = trig_sel;
      if (wr_go) begin
         case (addr)
            uic_pkg::OFS_DATA: begin
               if (dlab) begin
                  next_divisor_low_reg = data_in;
               end
            end
            uic_pkg::OFS_IER: begin
               if (dlab) begin
                  next_divisor_high_reg = data_in;
               end else begin
                  next_int_enable_reg = data_in[3:0];
               end
            end
            uic_pkg::OFS_ISR_FCR: begin
               next_fifo_en = data_in[uic_pkg::FCR_EN];
               if (data_in[uic_pkg::FCR_EN]) begin
                  next_dma_mode = data_in[uic_pkg::FCR_DMA];
                  next_trig_sel = data_in[uic_pkg::FCR_TRIG_LO +: 2];
               end
            end
            uic_pkg::OFS_LCR: next_line_ctrl_reg = data_in;
            uic_pkg::OFS_MCR: next_modem_ctrl_reg = data_in[4:0];
            uic_pkg::OFS_SCRATCH: next_scratch_reg = data_in;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         line_ctrl_reg <= uic_pkg::RST_LCR;
         modem_ctrl_reg <= uic_pkg::RST_MCR;
         scratch_reg <= uic_pkg::RST_SCRATCH;
         divisor_low_reg <= uic_pkg::RST_DIV;
         divisor_high_reg <= uic_pkg::RST_DIV;
         int_enable_reg <= uic_pkg::RST_IER;
         fifo_en <= 1'b0;
         dma_mode <= 1'b0;
         trig_sel <= uic_pkg::RST_TRIG;
      end else begin
         line_ctrl_reg <= next_line_ctrl_reg;
         modem_ctrl_reg <= next_modem_ctrl_reg;
         scratch_reg <= next_scratch_reg;
         divisor_low_reg <= next_divisor_low_reg;
         divisor_high_reg <= next_divisor_high_reg;
         int_enable_reg <= next_int_enable_reg;
         fifo_en <= next_fifo_en;
         dma_mode <= next_dma_mode;
         trig_sel <= next_trig_sel;
      end
   end

   // FIFO pointers; a reset touches only pointers and counts, never the shifters.
   always_comb begin
      next_rx_rp = rx_pop ? rx_rp + 1'b1 : rx_rp;
      next_rx_wp = rx_push ? rx_wp + 1'b1 : rx_wp;
      next_rx_cnt = rx_cnt + CW'(rx_push) - CW'(rx_pop);
      next_tx_rp = tx_pop ? tx_rp + 1'b1 : tx_rp;
      next_tx_wp = tx_push ? tx_wp + 1'b1 : tx_wp;
      next_tx_cnt = tx_cnt + CW'(tx_push) - CW'(tx_pop);
      if (rx_clr) begin
         next_rx_rp = '0;
         next_rx_wp = '0;
         next_rx_cnt = '0;
      end
      if (tx_clr) begin
         next_tx_rp = '0;
         next_tx_wp = '0;
         next_tx_cnt = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rx_rp <= '0;
         rx_wp <= '0;
         rx_cnt <= '0;
         tx_rp <= '0;
         tx_wp <= '0;
         tx_cnt <= '0;
      end else begin
         rx_rp <= next_rx_rp;
         rx_wp <= next_rx_wp;
         rx_cnt <= next_rx_cnt;
         tx_rp <= next_tx_rp;
         tx_wp <= next_tx_wp;
         tx_cnt <= next_tx_cnt;
      end
   end

   // Storage arrays carry no reset; only the pointers qualify their contents.
   always_ff @(posedge clock) begin
      if (rx_push) begin
         rx_mem[rx_wp] <= {rx_break, rx_frame_err, rx_parity_err, rx_char_data};
      end
      if (tx_push) begin
         tx_mem[tx_wp] <= data_in;
      end
   end

   // Interrupt flags. Hardware sets beat software clears arriving in the same cycle.
   always_comb begin
      next_overrun = (rx_char_valid && !rx_push) || (overrun && !lsr_rd);
      // A fresh head character reopens the line interrupt for its own tags.
      next_ls_seen = ls_seen;
      if (rx_pop || rx_clr) begin
         next_ls_seen = 1'b0;
      end else if (lsr_rd) begin
         next_ls_seen = 1'b1;
      end
      // Timer restarts on arrival or read; it saturates at the limit.
      next_tmo_cnt = tmo_cnt;
      if (rx_push || rx_pop || !rx_any || !fifo_en) begin
         next_tmo_cnt = '0;
      end else if (bit_tick && tmo_cnt < tmo_limit) begin
         next_tmo_cnt = tmo_cnt + 7'h01;
      end
      next_thre_int = (tx_empty && !tx_empty_q)
                      || (ier_wr && data_in[uic_pkg::IER_THRE]
                          && !int_enable_reg[uic_pkg::IER_THRE] && tx_empty)
                      || (thre_int && !thr_wr
                          && !(isr_rd && src_code == uic_pkg::SRC_THRE));
      next_mdm_delta = (mdm ^ mdm_q) | (mdm_delta & ~{4{msr_rd}});
      next_rx_dma_act = rx_dma_act;
      if (!rx_any) begin
         next_rx_dma_act = 1'b0;
      end else if (rxd_lvl || tmo_hit) begin
         next_rx_dma_act = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         overrun <= 1'b0;
         ls_seen <= 1'b0;
         tmo_cnt <= '0;
         thre_int <= 1'b0;
         tx_empty_q <= 1'b1;
         mdm_q <= mdm;
         mdm_delta <= '0;
         rx_dma_act <= 1'b0;
      end else begin
         overrun <= next_overrun;
         ls_seen <= next_ls_seen;
         tmo_cnt <= next_tmo_cnt;
         thre_int <= next_thre_int;
         tx_empty_q <= tx_empty;
         mdm_q <= mdm;
         mdm_delta <= next_mdm_delta;
         rx_dma_act <= next_rx_dma_act;
      end
   end

   // Read data is captured once, as the read is taken, so that its own side effects never show.
   logic [7:0] isr_val, lsr_val;
   assign isr_val = {fifo_en, fifo_en, 2'b00, src_code};
   assign lsr_val = {fifo_err,
                     tx_empty && tx_shift_empty,
                     tx_empty,
                     rx_any ? rx_head[10:8] : 3'b000,
                     overrun,
                     rx_any};
   always_comb begin
      next_data_out = data_out;
      if (rd_go) begin
         case (addr)
            uic_pkg::OFS_DATA: next_data_out = dlab ? divisor_low_reg : rx_head[7:0];
            uic_pkg::OFS_IER: next_data_out = dlab ? divisor_high_reg : {4'h0, int_enable_reg};
            uic_pkg::OFS_ISR_FCR: next_data_out = isr_val;
            uic_pkg::OFS_LCR: next_data_out = line_ctrl_reg;
            uic_pkg::OFS_MCR: next_data_out = {3'h0, modem_ctrl_reg};
            uic_pkg::OFS_LSR: next_data_out = lsr_val;
            uic_pkg::OFS_MSR: next_data_out = {mdm, mdm_delta};
            uic_pkg::OFS_SCRATCH: next_data_out = scratch_reg;
            default: next_data_out = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         data_out <= 8'h00;
      end else begin
         rd_q <= rd_act;
         wr_q <= wr_act;
         data_out <= next_data_out;
      end
   end

   // Pins. DMA signalling only applies while the FIFOs are on.
   assign data_oe = rd_q;
   assign irq = ~src_code[0];
   assign irq_oe = modem_ctrl_reg[uic_pkg::MCR_OUT2];
   assign rx_ready_pin_n = (fifo_en && dma_mode) ? ~rx_dma_act : ~rx_any;
   assign tx_ready_pin_n = (fifo_en && dma_mode) ? (tx_cnt == CAP_FULL) : !tx_empty;
   assign tx_valid = !tx_empty;
   assign tx_data = tx_mem[tx_rp];
   assign divisor = {divisor_high_reg, divisor_low_reg};
   assign line_ctrl = line_ctrl_reg;
   assign dtr_n = ~modem_ctrl_reg[uic_pkg::MCR_DTR];
   assign rts_n = ~modem_ctrl_reg[uic_pkg::MCR_RTS];
   assign aux_out1_n = ~modem_ctrl_reg[uic_pkg::MCR_OUT1];
   assign aux_out2_n = ~modem_ctrl_reg[uic_pkg::MCR_OUT2];
   assign loopback = modem_ctrl_reg[uic_pkg::MCR_LOOP];
endmodule

// ---- include/uic_pkg.sv ----
package uic_pkg;
   // Register offsets on the three address lines.
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IER = 3'h1;
   localparam logic [2:0] OFS_ISR_FCR = 3'h2;
   localparam logic [2:0] OFS_LCR = 3'h3;
   localparam logic [2:0] OFS_MCR = 3'h4;
   localparam logic [2:0] OFS_LSR = 3'h5;
   localparam logic [2:0] OFS_MSR = 3'h6;
   localparam logic [2:0] OFS_SCRATCH = 3'h7;
   // Interrupt enable fields.
   localparam int IER_RXD = 0;
   localparam int IER_THRE = 1;
   localparam int IER_LS = 2;
   localparam int IER_MDM = 3;
   // FIFO control fields.
   localparam int FCR_EN = 0;
   localparam int FCR_RXRST = 1;
   localparam int FCR_TXRST = 2;
   localparam int FCR_DMA = 3;
   localparam int FCR_TRIG_LO = 6;
   // Line control fields.
   localparam int LCR_DLAB = 7;
   localparam int LCR_PEN = 3;
   localparam int LCR_STB = 2;
   // Modem control fields.
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_OUT1 = 2;
   localparam int MCR_OUT2 = 3;
   localparam int MCR_LOOP = 4;
   // Interrupt source codes, highest priority first.
   localparam logic [3:0] SRC_LS = 4'h6;
   localparam logic [3:0] SRC_TMO = 4'hC;
   localparam logic [3:0] SRC_RXD = 4'h4;
   localparam logic [3:0] SRC_THRE = 4'h2;
   localparam logic [3:0] SRC_MDM = 4'h0;
   localparam logic [3:0] SRC_NONE = 4'h1;
   // Receive trigger levels in characters.
   localparam logic [4:0] TRIG_1 = 5'h01;
   localparam logic [4:0] TRIG_4 = 5'h04;
   localparam logic [4:0] TRIG_8 = 5'h08;
   localparam logic [4:0] TRIG_14 = 5'h0E;
   // Reset values.
   localparam logic [3:0] RST_IER = 4'h0;
   localparam logic [7:0] RST_LCR = 8'h00;
   localparam logic [4:0] RST_MCR = 5'h00;
   localparam logic [7:0] RST_DIV = 8'h00;
   localparam logic [7:0] RST_SCRATCH = 8'h00;
   localparam logic [1:0] RST_TRIG = 2'h0;
   // Receive timeout, in bit times: chars times frame length plus extra bits.
   localparam logic [6:0] TMO_CHARS = 7'h04;
   localparam logic [6:0] TMO_EXTRA_BITS = 7'h0C;
   localparam logic [6:0] FRAME_BASE_BITS = 7'h07;
   // Documented FIFO depth.
   localparam int FIFO_DEPTH_DEF = 16;
endpackage

// ---- dv/uic_checker.sv ----
`timescale 1ns/1ns
// Watches the host bus and the pins of one channel.
module uic_checker (
   input wire logic clock,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic irq,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_take,
   input wire logic [15:0] divisor,
   input wire logic [7:0] line_ctrl
);
   logic rd_q, wr_q, next_rd_q, next_wr_q, rd_go, wr_go, rd_hold;
   // Edge detect, so that a strobe held low counts as one access only.
   always_comb begin
      next_rd_q = !cs_n && !rd_n;
      next_wr_q = !cs_n && !wr_n;
   end
   always_ff @(posedge clock) begin
      rd_q <= next_rd_q;
      wr_q <= next_wr_q;
   end
   assign rd_go = next_rd_q && !rd_q;
   assign wr_go = next_wr_q && !wr_q;
   assign rd_hold = next_rd_q;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   reset_clear_a: assert property ($fell(srst) |-> !irq && !data_oe && divisor == 16'h0000)
      else $error("outputs not quiet after reset");
   read_drive_a: assert property (rd_go ##1 rd_hold |=> data_oe)
      else $error("read not driven on the data bus");
   drive_release_a: assert property ((cs_n || rd_n) [*2] |-> !data_oe)
      else $error("data bus still driven after the read");
   ier_upper_a: assert property (rd_go && addr == uic_pkg::OFS_IER && !line_ctrl[7] ##1 rd_hold
      |=> data_out[7:4] == 4'h0)
      else $error("enable register upper bits not zero");
   isr_fixed_a: assert property (rd_go && addr == uic_pkg::OFS_ISR_FCR ##1 rd_hold
      |=> data_out[5:4] == 2'h0 && data_out[7] == data_out[6])
      else $error("status upper bits malformed");
   isr_code_a: assert property (rd_go && addr == uic_pkg::OFS_ISR_FCR ##1 rd_hold
      |=> data_out[3:0] inside {4'h6, 4'hC, 4'h4, 4'h2, 4'h0, 4'h1})
      else $error("status source code not legal");
   div_low_a: assert property (wr_go && addr == 3'h0 && line_ctrl[7]
      |-> ##2 divisor[7:0] == $past(data_in, 2))
      else $error("low divisor not written");
   div_high_a: assert property (wr_go && addr == 3'h1 && line_ctrl[7]
      |-> ##2 divisor[15:8] == $past(data_in, 2))
      else $error("high divisor not written");
   tx_accept_a: assert property (wr_go && addr == 3'h0 && !line_ctrl[7] && !tx_valid && !tx_take
      ##1 !tx_take |=> tx_valid && tx_data == $past(data_in, 2))
      else $error("transmit write not taken");
endmodule

bind uic_channel uic_checker u_chk (.clock(clock), .srst(srst), .cs_n(cs_n), .rd_n(rd_n),
   .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
   .irq(irq), .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .divisor(divisor),
   .line_ctrl(line_ctrl));

// ---- dv/uic_host.sv ----
`timescale 1ns/1ns
// Host processor model: one access at a time, strobes changed only at falling edges.
module uic_host (
   input wire logic clock,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [2:0] addr,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 3'h0;
      data_in = 8'h00;
   end
   // The released bus shows the inverse of the last byte, so stale data never matches.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clock);
      cs_n = 1'b0;
      wr_n = 1'b0;
      addr = a;
      data_in = d;
      @(negedge clock);
      cs_n = 1'b1;
      wr_n = 1'b1;
      data_in = ~d;
   endtask
   // Holds the read over two rising edges, then takes the answer.
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge clock);
      cs_n = 1'b0;
      rd_n = 1'b0;
      addr = a;
      repeat (2) @(negedge clock);
      d = data_out;
      cs_n = 1'b1;
      rd_n = 1'b1;
   endtask
endmodule

// ---- dv/uic_interrupt_fifo_control_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module uic_interrupt_fifo_control_tb_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic cs_n, rd_n, wr_n, data_oe, irq, irq_oe, rx_rdy_n, tx_rdy_n, tx_valid;
   logic [2:0] addr;
   logic [7:0] data_in, data_out, tx_data, v, d0, d1;
   logic [15:0] divisor;
   logic rx_char_valid = 1'b0;
   logic [7:0] rx_char_data = 8'h00;
   logic [2:0] rx_err = 3'h0;
   logic bit_tick = 1'b0;
   logic tx_take = 1'b0;
   logic tx_shift_empty = 1'b1;
   logic cts_n = 1'b1;
   logic [31:0] seed = 32'h0807;
   logic [7:0] q[$];
   int n_fail = 0;
   int num_checks = 0;
   always #5 clock = ~clock;
   uic_host u_h (.clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .data_in(data_in), .data_out(data_out));
   uic_channel u_uic_channel (.clock(clock), .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .rx_parity_err(rx_err[0]),
      .rx_frame_err(rx_err[1]), .rx_break(rx_err[2]), .bit_tick(bit_tick), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_take(tx_take), .tx_shift_empty(tx_shift_empty), .cts_n(cts_n),
      .dsr_n(1'b1), .ri_n(1'b1), .cd_n(1'b1), .irq(irq), .irq_oe(irq_oe),
      .rx_ready_pin_n(rx_rdy_n), .tx_ready_pin_n(tx_rdy_n), .divisor(divisor), .line_ctrl(),
      .dtr_n(), .rts_n(), .aux_out1_n(), .aux_out2_n(), .loopback());
   // Xorshift keeps the random bytes repeatable from run to run.
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic int lvl(input int t);
      return (t == 0) ? 1 : (t == 1) ? 4 : (t == 2) ? 8 : 14;
   endfunction
   function automatic logic [7:0] interrupt_status(input logic f, input logic [3:0] c);
      return {f, f, 2'b00, c};
   endfunction
   // Reads a register and compares the masked bits.
   task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      u_h.rd(a, v);
      `CHK(v & m, e)
   endtask
   // One received character, recorded for later comparison.
   task automatic push(input logic [2:0] e);
      @(negedge clock);
      rx_char_valid = 1'b1;
      rx_char_data = rnd();
      rx_err = e;
      q.push_back(rx_char_data);
      @(negedge clock);
      rx_char_valid = 1'b0;
      rx_char_data = ~rx_char_data;
   endtask
   task automatic pulse_take();
      @(negedge clock);
      tx_take = 1'b1;
      @(negedge clock);
      tx_take = 1'b0;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clock);
         bit_tick = 1'b1;
         @(negedge clock);
         bit_tick = 1'b0;
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // A hang is cut short well after the expected run of a few hundred cycles.
   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (6) @(negedge clock);
      srst = 1'b0;
      rdc(3'h1, 8'hFF, 8'h00);
      rdc(3'h2, 8'hFF, interrupt_status(1'b0, uic_pkg::SRC_NONE));
      u_h.wr(3'h1, 8'hFF);
      rdc(3'h1, 8'hFF, 8'h0F);
      `CHK(irq, 1'b1)
      rdc(3'h2, 8'hFF, interrupt_status(1'b0, uic_pkg::SRC_THRE));
      rdc(3'h2, 8'hFF, interrupt_status(1'b0, uic_pkg::SRC_NONE));
      d0 = rnd();
      u_h.wr(3'h0, d0);
      `CHK(tx_data, d0)
      pulse_take();
      rdc(3'h2, 8'hFF, interrupt_status(1'b0, uic_pkg::SRC_THRE));
      rdc(3'h5, 8'h40, 8'h40);
      tx_shift_empty = 1'b0;
      rdc(3'h5, 8'h40, 8'h00);
      tx_shift_empty = 1'b1;
      u_h.wr(3'h0, rnd());
      rdc(3'h2, 8'hFF, interrupt_status(1'b0, uic_pkg::SRC_NONE));
      pulse_take();
      u_h.wr(3'h3, 8'h80);
      d0 = rnd();
      d1 = rnd();
      u_h.wr(3'h0, d0);
      u_h.wr(3'h1, d1);
      `CHK(divisor, {d1, d0})
      rdc(3'h0, 8'hFF, d0);
      u_h.wr(3'h3, 8'h03);
      rdc(3'h1, 8'hFF, 8'h0F);
      // Two characters with no FIFO overrun the single holding stage.
      u_h.wr(3'h1, 8'h05);
      push(3'h0);
      push(3'h0);
      rdc(3'h2, 8'hFF, interrupt_status(1'b0, uic_pkg::SRC_LS));
      rdc(3'h5, 8'h03, 8'h03);
      rdc(3'h2, 8'hFF, interrupt_status(1'b0, uic_pkg::SRC_RXD));
      rdc(3'h0, 8'hFF, q[0]);
      rdc(3'h5, 8'h01, 8'h00);
      u_h.wr(3'h2, 8'h01);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
      for (int t = 0; t < 4; t++) begin
         q.delete();
         u_h.wr(3'h2, {t[1:0], 6'h03});
         for (int n = 1; n < lvl(t); n++) push(3'h0);
         rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
         push(3'h0);
         rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_RXD));
         `CHK(rx_rdy_n, 1'b0)
         rdc(3'h0, 8'hFF, q[0]);
         rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
         rdc(3'h5, 8'h01, (t == 0) ? 8'h00 : 8'h01);
      end
      u_h.wr(3'h2, 8'h43);
      rdc(3'h5, 8'h01, 8'h00);
      // Word length code 3, no parity, one stop: the wait is 52 bit times.
      push(3'h0);
      ticks(50);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
      ticks(4);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_TMO));
      u_h.rd(3'h0, v);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
      u_h.wr(3'h1, 8'h04);
      push(3'h0);
      push(3'h1);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
      rdc(3'h5, 8'h84, 8'h80);
      u_h.rd(3'h0, v);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_LS));
      rdc(3'h5, 8'h84, 8'h84);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
      u_h.rd(3'h0, v);
      rdc(3'h5, 8'h80, 8'h00);
      u_h.wr(3'h1, 8'h08);
      cts_n = 1'b0;
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_MDM));
      rdc(3'h6, 8'h01, 8'h01);
      rdc(3'h2, 8'hFF, interrupt_status(1'b1, uic_pkg::SRC_NONE));
      u_h.wr(3'h1, 8'h00);
      u_h.wr(3'h0, rnd());
      `CHK(tx_rdy_n, 1'b1)
      u_h.wr(3'h2, 8'h09);
      `CHK(tx_rdy_n, 1'b0)
      print_verdict();
   end
endmodule
